// file: hdl/watchdog_interval_pkg.sv
package watchdog_interval_pkg;

    // ****************************************
    // register map (word index = address)
    // ****************************************
    localparam logic [2:0] ADDR_COUNTER   = 3'h0;
    localparam logic [2:0] ADDR_CONTROL   = 3'h1;
    localparam logic [2:0] ADDR_IRQ_STAT  = 3'h2;
    localparam logic [2:0] ADDR_IRQ_EN    = 3'h3;
    localparam logic [2:0] ADDR_IRQ_CLR   = 3'h4;

    // keys expected in the upper write byte
    localparam logic [7:0] KEY_COUNTER    = 8'h5a;
    localparam logic [7:0] KEY_CONTROL    = 8'ha5;

    // ****************************************
    // control/status layout
    // ****************************************
    localparam int         BIT_FLAG       = 7;
    localparam int         BIT_MODE       = 6;
    localparam int         BIT_ENABLE     = 5;
    localparam logic [1:0] RESERVED_ONES  = 2'h3;
    localparam logic [7:0] COUNTER_RESET  = 8'h00;
    localparam logic [7:0] COUNTER_MAX    = 8'hff;
    localparam logic       MODE_INTERVAL  = 1'b0;
    localparam logic       MODE_WATCHDOG  = 1'b1;

    typedef struct packed {
        logic       overflow_flag;
        logic       mode_select;
        logic       count_enable;
        logic [2:0] clock_divider_select;
    } control_t;

    localparam control_t CONTROL_RESET = '{1'b0, 1'b0, 1'b0, 3'h0};

    // irq status bits
    localparam int IRQ_INTERVAL = 0;
    localparam int IRQ_WATCHDOG = 1;
    localparam int IRQ_W        = 2;

    // ****************************************
    // timing
    // ****************************************
    localparam int PRESCALE_W   = 13;
    localparam int PULSE_CYCLES = 128;

    // divide ratio as a power of two: 2,64,128,256,512,1024,4096,8192
    function automatic logic [3:0] divide_shift(input logic [2:0] sel);
        logic [3:0] sh;
        sh = 4'h1;
        unique case (sel)
            3'h0: sh = 4'h1;
            3'h1: sh = 4'h6;
            3'h2: sh = 4'h7;
            3'h3: sh = 4'h8;
            3'h4: sh = 4'h9;
            3'h5: sh = 4'ha;
            3'h6: sh = 4'hc;
            3'h7: sh = 4'hd;
        endcase
        return sh;
    endfunction : divide_shift

endpackage : watchdog_interval_pkg

// file: hdl/watchdog_interval_counter.sv
// Notes on behaviour
// - 8-bit readable, writable up-counter, one step per divided tick while enabled.
// - wrap from all-ones to zero gives watchdog output or interval interrupt by mode.
// - counter holds zero after reset.
// - interval-mode wrap sets overflow flag bit 7; watchdog mode never sets it.
// - with count enable written 1, flag clears only by writing 0 after reading it as 1; writing 1 does nothing.
// - in interval mode, writing count enable 0 also clears the flag.
// - mode bit 6: 0 interval with interrupt, 1 watchdog with external output.
// - count enable bit 5 starts counting; at 0 counter is zero and stopped.
// - bits 4 and 3 read as 1; software writes 1 there.
// - clock select 000 /2, 001 /64, 010 /128, 011 /256.
// - clock select 100 /512, 101 /1024, 110 /4096, 111 /8192.
// - timer registers accept only keyed writes; software must use them.
// - overflow time is 256 divided ticks counted from zero.
// - watchdog overflow drives the external output for 128 clock cycles.
// - interval interrupt request rises in the cycle the flag is set.
`timescale 1ns/1ps
`default_nettype none

module watchdog_interval_counter
    import watchdog_interval_pkg::*;
#(
    parameter int PRESCALE_BITS = PRESCALE_W,
    parameter int OVF_PULSE     = PULSE_CYCLES
)
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic [2:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WRITE,
    input  wire logic        READ,
    output var  logic [7:0]  RDATA,
    output var  logic        WATCHDOG_OVERFLOW_OUT_N,
    output var  logic        PERIODIC_IRQ,
    output var  logic        IRQ
);
    import watchdog_interval_pkg::*;

    // ****************************************
    // elaboration checks
    // ****************************************
    if (PRESCALE_BITS < PRESCALE_W)
    begin : g_bad_prescale
        $error("prescaler too narrow for the largest divide ratio");
    end
    if (OVF_PULSE < 1 || OVF_PULSE > 255)
    begin : g_bad_pulse
        $error("overflow pulse length must be 1 to 255");
    end

    localparam logic [7:0] PULSE_LEN = 8'(OVF_PULSE);

    // ****************************************
    // state
    // ****************************************
    control_t                   control;
    logic [7:0]                 wdt_counter;
    logic [PRESCALE_BITS-1:0]   prescaler;
    logic [PRESCALE_BITS-1:0]   tick_mask;
    logic                       tick;
    logic                       wrap;
    logic                       flag_read_one;
    logic [7:0]                 pulse_left;
    logic [IRQ_W-1:0]           irq_status;
    logic [IRQ_W-1:0]           irq_enable;
    logic [IRQ_W-1:0]           next_irq_status;
    logic                       counter_wr;
    logic                       control_wr;
    logic                       flag_clear;

    // a wrong key drops the whole write
    assign counter_wr = WRITE && ADDR == ADDR_COUNTER && WDATA[15:8] == KEY_COUNTER;
    assign control_wr = WRITE && ADDR == ADDR_CONTROL && WDATA[15:8] == KEY_CONTROL;

    // ****************************************
    // prescaler
    // ****************************************
    assign tick_mask = PRESCALE_BITS'((1 << divide_shift(control.clock_divider_select)) - 1);
    assign tick      = control.count_enable && (prescaler & tick_mask) == tick_mask;

    // cleared while stopped, so the first step is a full period away
    always_ff @(posedge CLK)
    begin
        if (RESET || !control.count_enable)
            prescaler <= '0;
        else
            prescaler <= prescaler + 1'b1;
    end

    // ****************************************
    // counter
    // ****************************************
    assign wrap = tick && wdt_counter == COUNTER_MAX && !counter_wr;

    always_ff @(posedge CLK)
    begin
        if (RESET)
            wdt_counter <= COUNTER_RESET;
        else if (!control.count_enable)
            wdt_counter <= COUNTER_RESET;
        else if (counter_wr)
            wdt_counter <= WDATA[7:0];
        else if (tick)
            wdt_counter <= wdt_counter + 8'h01;
    end

    // ****************************************
    // control/status
    // ****************************************
    // with enable written 1, clear needs a prior read of 1 and a write of 1 leaves the flag alone
    assign flag_clear = control_wr && (
        (!WDATA[BIT_FLAG] && flag_read_one) ||
        (!WDATA[BIT_ENABLE] && control.mode_select == MODE_INTERVAL));

    always_ff @(posedge CLK)
    begin
        if (RESET)
            control <= CONTROL_RESET;
        else
        begin
            if (control_wr)
            begin
                control.mode_select          <= WDATA[BIT_MODE];
                control.count_enable         <= WDATA[BIT_ENABLE];
                control.clock_divider_select <= WDATA[2:0];
            end
            // set beats a clear in the same cycle
            if (wrap && control.mode_select == MODE_INTERVAL)
                control.overflow_flag <= 1'b1;
            else if (flag_clear)
                control.overflow_flag <= 1'b0;
        end
    end

    // remembers that software saw the flag set
    always_ff @(posedge CLK)
    begin
        if (RESET || control_wr)
            flag_read_one <= 1'b0;
        else if (READ && ADDR == ADDR_CONTROL && control.overflow_flag)
            flag_read_one <= 1'b1;
    end

    // interrupt request is its own register, set and cleared with the flag
    always_ff @(posedge CLK)
    begin
        if (RESET)
            PERIODIC_IRQ <= 1'b0;
        else if (wrap && control.mode_select == MODE_INTERVAL)
            PERIODIC_IRQ <= 1'b1;
        else if (flag_clear)
            PERIODIC_IRQ <= 1'b0;
    end

    // ****************************************
    // watchdog output pulse
    // ****************************************
    always_ff @(posedge CLK)
    begin
        if (RESET)
            pulse_left <= 8'h00;
        else if (wrap && control.mode_select == MODE_WATCHDOG)
            pulse_left <= PULSE_LEN;
        else if (pulse_left != 8'h00)
            pulse_left <= pulse_left - 8'h01;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            WATCHDOG_OVERFLOW_OUT_N <= 1'b1;
        else if (wrap && control.mode_select == MODE_WATCHDOG)
            WATCHDOG_OVERFLOW_OUT_N <= 1'b0;
        else if (pulse_left == 8'h01)
            WATCHDOG_OVERFLOW_OUT_N <= 1'b1;
    end

    // ****************************************
    // interrupt status, enable, clear
    // ****************************************
    always_comb
    begin
        next_irq_status = irq_status;
        if (WRITE && ADDR == ADDR_IRQ_CLR)
            next_irq_status = irq_status & ~WDATA[IRQ_W-1:0];
        if (wrap && control.mode_select == MODE_INTERVAL)
            next_irq_status[IRQ_INTERVAL] = 1'b1;
        if (wrap && control.mode_select == MODE_WATCHDOG)
            next_irq_status[IRQ_WATCHDOG] = 1'b1;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            irq_status <= '0;
        else
            irq_status <= next_irq_status;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            irq_enable <= '0;
        else if (WRITE && ADDR == ADDR_IRQ_EN)
            irq_enable <= WDATA[IRQ_W-1:0];
    end

    // registered from the value the status takes this edge
    always_ff @(posedge CLK)
    begin
        if (RESET)
            IRQ <= 1'b0;
        else
            IRQ <= |(next_irq_status & irq_enable);
    end

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge CLK)
    begin
        if (RESET)
            RDATA <= 8'h00;
        else if (READ)
        begin
            unique case (ADDR)
                ADDR_COUNTER:  RDATA <= wdt_counter;
                ADDR_CONTROL:  RDATA <= {control.overflow_flag, control.mode_select,
                                         control.count_enable, RESERVED_ONES,
                                         control.clock_divider_select};
                ADDR_IRQ_STAT: RDATA <= 8'(irq_status);
                ADDR_IRQ_EN:   RDATA <= 8'(irq_enable);
                default:       RDATA <= 8'h00;
            endcase
        end
        else
            RDATA <= 8'h00;
    end

    // ****************************************
    // checks
    // ****************************************
    property p_reset_zero;
        @(posedge CLK) disable iff (RESET)
        $fell(RESET) |-> wdt_counter == COUNTER_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("counter not zero after reset");

    property p_disabled_zero;
        @(posedge CLK) disable iff (RESET)
        !control.count_enable |=> wdt_counter == COUNTER_RESET && prescaler == '0;
    endproperty
    a_disabled_zero: assert property (p_disabled_zero) else $error("stopped timer not cleared");

    property p_step;
        @(posedge CLK) disable iff (RESET)
        tick && !counter_wr |=> wdt_counter == $past(wdt_counter) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("counter did not step on tick");

    property p_interval_flag;
        @(posedge CLK) disable iff (RESET)
        wrap && control.mode_select == MODE_INTERVAL |=> control.overflow_flag && PERIODIC_IRQ;
    endproperty
    a_interval_flag: assert property (p_interval_flag) else $error("interval wrap lost");

    property p_no_flag_watchdog;
        @(posedge CLK) disable iff (RESET)
        $rose(control.overflow_flag) |-> $past(control.mode_select) == MODE_INTERVAL;
    endproperty
    a_no_flag_watchdog: assert property (p_no_flag_watchdog) else $error("flag set in watchdog mode");

    property p_write_one_keeps;
        @(posedge CLK) disable iff (RESET)
        control_wr && WDATA[BIT_FLAG] && WDATA[BIT_ENABLE] && control.overflow_flag
            |=> control.overflow_flag;
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps) else $error("flag cleared by a 1");

    // cycles since the last watchdog wrap, held at its top; only the pulse check reads it
    logic [8:0]                 wd_age;

    always_ff @(posedge CLK)
    begin
        if (RESET)
            wd_age <= '1;
        else if (wrap && control.mode_select == MODE_WATCHDOG)
            wd_age <= '0;
        else if (wd_age != '1)
            wd_age <= wd_age + 9'h001;
    end

    property p_pulse;
        @(posedge CLK) disable iff (RESET)
        WATCHDOG_OVERFLOW_OUT_N == (wd_age >= {1'b0, PULSE_LEN});
    endproperty
    a_pulse: assert property (p_pulse) else $error("watchdog pulse length wrong");

    property p_bad_key;
        @(posedge CLK) disable iff (RESET)
        WRITE && ADDR == ADDR_CONTROL && WDATA[15:8] != KEY_CONTROL
            |=> $stable(control.mode_select) && $stable(control.clock_divider_select);
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("unkeyed write took effect");

    property p_irq_follows_flag;
        @(posedge CLK) disable iff (RESET)
        PERIODIC_IRQ == control.overflow_flag;
    endproperty
    a_irq_follows_flag: assert property (p_irq_follows_flag) else $error("interval request differs from flag");

    property p_reserved_ones;
        @(posedge CLK) disable iff (RESET)
        READ && ADDR == ADDR_CONTROL |=> RDATA[4:3] == RESERVED_ONES;
    endproperty
    a_reserved_ones: assert property (p_reserved_ones) else $error("reserved bits not read as ones");

    property p_enable_clear;
        @(posedge CLK) disable iff (RESET)
        control_wr && !WDATA[BIT_ENABLE] && control.mode_select == MODE_INTERVAL && !wrap
            |=> !control.overflow_flag;
    endproperty
    a_enable_clear: assert property (p_enable_clear) else $error("stopping interval timer kept flag");

    property p_no_blind_clear;
        @(posedge CLK) disable iff (RESET)
        control_wr && !flag_read_one && WDATA[BIT_ENABLE] && control.overflow_flag
            |=> control.overflow_flag;
    endproperty
    a_no_blind_clear: assert property (p_no_blind_clear) else $error("flag cleared without a prior read");

    property p_keyed_counter;
        @(posedge CLK) disable iff (RESET)
        WRITE && ADDR == ADDR_COUNTER && WDATA[15:8] != KEY_COUNTER && control.count_enable && !tick
            |=> $stable(wdt_counter);
    endproperty
    a_keyed_counter: assert property (p_keyed_counter) else $error("unkeyed counter write took effect");

    property p_watchdog_no_irq;
        @(posedge CLK) disable iff (RESET)
        wrap && control.mode_select == MODE_WATCHDOG |=> !$rose(PERIODIC_IRQ);
    endproperty
    a_watchdog_no_irq: assert property (p_watchdog_no_irq) else $error("watchdog wrap raised interval request");

endmodule : watchdog_interval_counter

`default_nettype wire

// file: sim/wdt_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module wdt_host_model
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        wdt_out_n,
    input  wire logic        periodic_irq,
    output logic      [15:0] pulse_len,
    output logic      [15:0] pulse_count,
    output logic      [15:0] irq_rises
);
    logic [15:0] run;
    logic        out_q;
    logic        irq_q;

    // ****************************************
    // system reset circuit: width of each low pulse
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            run         <= '0;
            pulse_len   <= '0;
            pulse_count <= '0;
            out_q       <= 1'b1;
        end
        else
        begin
            out_q <= wdt_out_n;
            run   <= wdt_out_n ? 16'h0000 : run + 16'h0001;
            if (!wdt_out_n && out_q)
                pulse_count <= pulse_count + 16'h0001;
            if (wdt_out_n && !out_q)
                pulse_len <= run;
        end
    end

    // ****************************************
    // cpu side: interval requests taken
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            irq_q     <= 1'b0;
            irq_rises <= '0;
        end
        else
        begin
            irq_q <= periodic_irq;
            if (periodic_irq && !irq_q)
                irq_rises <= irq_rises + 16'h0001;
        end
    end
endmodule : wdt_host_model

`default_nettype wire

// file: sim/watchdog_interval_counter_tb.sv
`timescale 1ns/1ps
`default_nettype none

module watchdog_interval_counter_tb;
    import watchdog_interval_pkg::*;
    localparam int PULSE = 8;
    logic        CLK = 1'b0, RESET = 1'b1, WRITE = 1'b0, READ = 1'b0;
    logic [2:0]  ADDR = 3'h0;
    logic [15:0] WDATA = 16'h0000;
    logic [7:0]  RDATA, v;
    logic        WATCHDOG_OVERFLOW_OUT_N, PERIODIC_IRQ, IRQ;
    logic [15:0] pulse_len, pulse_count, irq_rises, rises_before;
    int          n_fail = 0, checks_done = 0, n;

    always #12.5 CLK = ~CLK;

    watchdog_interval_counter #(.PRESCALE_BITS(PRESCALE_W), .OVF_PULSE(PULSE)) dut_u
    (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE), .READ(READ), .RDATA(RDATA),
     .WATCHDOG_OVERFLOW_OUT_N(WATCHDOG_OVERFLOW_OUT_N), .PERIODIC_IRQ(PERIODIC_IRQ), .IRQ(IRQ));

    wdt_host_model host_u
    (.clk(CLK), .reset(RESET), .wdt_out_n(WATCHDOG_OVERFLOW_OUT_N), .periodic_irq(PERIODIC_IRQ),
     .pulse_len(pulse_len), .pulse_count(pulse_count), .irq_rises(irq_rises));

    // ****************************************
    // bus helpers: entered just after a rising edge
    // ****************************************
    function automatic logic [15:0] ctl(input logic fl, input logic md, input logic en, input logic [2:0] sel);
        return {KEY_CONTROL, fl, md, en, RESERVED_ONES, sel};
    endfunction : ctl

    // idle cycle after each write: back-to-back calls never lower and raise the strobe at once
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        ADDR  <= a;
        WDATA <= d;
        WRITE <= 1'b1;
        @(posedge CLK);
        WRITE <= 1'b0;
        @(posedge CLK);
    endtask : wr

    // one idle cycle after each read keeps the caller on an edge
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        ADDR <= a;
        READ <= 1'b1;
        @(posedge CLK);
        READ <= 1'b0;
        @(negedge CLK);
        d = RDATA;
        @(posedge CLK);
    endtask : rd

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rd(ADDR_COUNTER, v);
        check(v, COUNTER_RESET);
        rd(ADDR_CONTROL, v);
        check(v, 16'h0018);
        check(WATCHDOG_OVERFLOW_OUT_N, 16'h0001);
        check(PERIODIC_IRQ, 16'h0000);
        rd(3'h7, v);
        check(v, 16'h0000);
    endtask : t_reset

    task automatic t_keys;
        wr(ADDR_CONTROL, ctl(1'b0, 1'b0, 1'b1, 3'h7));
        wr(ADDR_COUNTER, 16'h0037);
        rd(ADDR_COUNTER, v);
        check(v, 16'h0000);
        wr(ADDR_COUNTER, {KEY_COUNTER, 8'h37});
        rd(ADDR_COUNTER, v);
        check(v, 16'h0037);
        wr(ADDR_CONTROL, 16'h0018);
        rd(ADDR_CONTROL, v);
        check(v, 16'h003f);
        wr(ADDR_CONTROL, ctl(1'b0, 1'b0, 1'b0, 3'h7));
        rd(ADDR_COUNTER, v);
        check(v, 16'h0000);
    endtask : t_keys

    // read half a tick after the first step: a larger ratio reads 0, a smaller one 0 or 3 or more
    task automatic t_divider;
        int divs [8];
        divs = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_CONTROL, ctl(1'b0, 1'b0, 1'b1, i[2:0]));
            repeat (divs[i] + divs[i] / 2 - 1) @(posedge CLK);
            rd(ADDR_COUNTER, v);
            check(v, 16'h0001);
            wr(ADDR_CONTROL, ctl(1'b0, 1'b0, 1'b0, i[2:0]));
        end
    endtask : t_divider

    task automatic wait_irq;
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
            @(negedge CLK);
        end while (PERIODIC_IRQ !== 1'b1 && n < 600);
        @(posedge CLK);
    endtask : wait_irq

    task automatic t_interval;
        wr(ADDR_IRQ_EN, 16'h0001);
        wr(ADDR_CONTROL, ctl(1'b0, MODE_INTERVAL, 1'b1, 3'h0));
        wait_irq();
        // waiting starts one edge after the enabling write is taken
        check(n[15:0] + 16'd1, 16'd512);
        check(IRQ, 16'h0001);
        rd(ADDR_CONTROL, v);
        check(v, 16'h00b8);
        wr(ADDR_CONTROL, ctl(1'b1, MODE_INTERVAL, 1'b1, 3'h0));
        wr(ADDR_CONTROL, ctl(1'b0, MODE_INTERVAL, 1'b1, 3'h0));
        rd(ADDR_CONTROL, v);
        check(v, 16'h00b8);
        wr(ADDR_CONTROL, ctl(1'b0, MODE_INTERVAL, 1'b1, 3'h0));
        rd(ADDR_CONTROL, v);
        check(v, 16'h0038);
        check(PERIODIC_IRQ, 16'h0000);
        wait_irq();
        wr(ADDR_IRQ_EN, 16'h0000);
        rd(ADDR_IRQ_STAT, v);
        check(v, 16'h0001);
        check(IRQ, 16'h0000);
        wr(ADDR_IRQ_EN, 16'h0001);
        rd(ADDR_IRQ_STAT, v);
        check(IRQ, 16'h0001);
        wr(ADDR_CONTROL, ctl(1'b0, MODE_INTERVAL, 1'b0, 3'h0));
        rd(ADDR_CONTROL, v);
        check(v, 16'h0018);
        check(PERIODIC_IRQ, 16'h0000);
        wr(ADDR_IRQ_CLR, 16'h0001);
        rd(ADDR_IRQ_STAT, v);
        check(v, 16'h0000);
        check(IRQ, 16'h0000);
        check(irq_rises, 16'h0002);
    endtask : t_interval

    task automatic t_watchdog;
        rises_before = irq_rises;
        wr(ADDR_IRQ_EN, 16'h0002);
        wr(ADDR_CONTROL, ctl(1'b0, MODE_WATCHDOG, 1'b1, 3'h0));
        wr(ADDR_COUNTER, {KEY_COUNTER, 8'hf0});
        n = 0;
        while (WATCHDOG_OVERFLOW_OUT_N !== 1'b0 && n < 100)
        begin
            @(posedge CLK);
            n++;
        end
        repeat (20) @(posedge CLK);
        check(pulse_count, 16'h0001);
        check(pulse_len, 16'(PULSE));
        rd(ADDR_CONTROL, v);
        check(v, 16'h0078);
        check(irq_rises, rises_before);
        rd(ADDR_IRQ_STAT, v);
        check(v, 16'h0002);
        check(IRQ, 16'h0001);
        wr(ADDR_CONTROL, ctl(1'b0, MODE_WATCHDOG, 1'b0, 3'h0));
    endtask : t_watchdog

    // reset in mid-count brings every register and output back to idle
    task automatic t_midreset;
        wr(ADDR_CONTROL, ctl(1'b0, MODE_INTERVAL, 1'b1, 3'h0));
        wr(ADDR_COUNTER, {KEY_COUNTER, 8'h40});
        RESET <= 1'b1;
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        rd(ADDR_COUNTER, v);
        check(v, COUNTER_RESET);
        rd(ADDR_CONTROL, v);
        check(v, 16'h0018);
        check(PERIODIC_IRQ, 16'h0000);
        check(IRQ, 16'h0000);
        check(WATCHDOG_OVERFLOW_OUT_N, 16'h0001);
    endtask : t_midreset

    // ****************************************
    // sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (10) @(posedge CLK);
        RESET <= 1'b0;
        t_reset();
        t_keys();
        t_divider();
        t_interval();
        t_watchdog();
        t_midreset();
        wrap_up();
    end

    initial
    begin
        repeat (40000) @(posedge CLK);
        n_fail++;
        wrap_up();
    end
endmodule : watchdog_interval_counter_tb

`default_nettype wire
